// *** verilog/at_timer_defines.svh ***
// register offsets, field positions, reset values and counts of the autoreload timer
`ifndef AT_TIMER_DEFINES_SVH
`define AT_TIMER_DEFINES_SVH
`define TCS_OFS 8'h0D
`define CNT_HI_OFS 8'h0E
`define CNT_LO_OFS 8'h0F
`define RLD_HI_OFS 8'h10
`define RLD_LO_OFS 8'h11
`define OUT_CTRL_OFS 8'h12
`define CH_CS_OFS 8'h13
`define DUTY_HI_OFS 8'h17
`define DUTY_LO_OFS 8'h18
`define TCS_CKSEL_HI 4
`define TCS_CKSEL_LO 3
`define TCS_OVF_BIT 2
`define TCS_OVERFLOW_IRQ_ENABLE_BIT 1
`define TCS_COMPARE_IRQ_ENABLE_BIT 0
`define CCS_POL_BIT 1
`define CCS_CMPF_BIT 0
`define OCTL_OE_BIT 0
`define REG_RESET 8'h00
`define CNT_RESET 12'h000
`define CNT_TOP 12'hFFF
`define SLOW_DIV_DEFAULT 32
`endif

// *** verilog/at_timer_pkg.sv ***
// types shared by the autoreload timer and its bench
package at_timer_pkg;
	typedef enum logic [1:0] {
		CLK_OFF = 2'b00,
		CLK_LITE = 2'b01,
		CLK_CPU = 2'b10,
		CLK_RSVD = 2'b11
	} clk_sel_e;
	typedef struct packed {
		clk_sel_e clkSel;
		logic overflow_irq_enable;
		logic compare_irq_enable;
		logic oe;
		logic pol;
	} ctrl_s;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bus_req_s;
	typedef struct packed {
		logic slow;
		logic waitMode;
		logic halt;
		logic activeHalt;
	} power_s;
endpackage

// *** verilog/autoreload_timer_pwm_compare.sv ***
// 12-bit autoreload timer with one pwm channel and output compare
`timescale 1ns/1ps
`include "at_timer_defines.svh"

module autoreload_timer_pwm_compare #(
	parameter int SLOW_DIV = `SLOW_DIV_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire at_timer_pkg::bus_req_s regReq,
	output logic [7:0] regRdata,
	input wire at_timer_pkg::power_s lowPower,
	input wire logic liteTick,
	input wire logic cpuIntMask,
	output logic pwmOut,
	output logic pwmOutEn,
	output logic ovfIrq,
	output logic cmpIrq,
	output logic wakeReq
);
	localparam int DIV_W = (SLOW_DIV > 1) ? $clog2(SLOW_DIV) : 1;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SLOW_DIV - 1);

	if (SLOW_DIV < 2)
	begin : g_badDiv
		$error("SLOW_DIV must be at least 2");
	end

	at_timer_pkg::ctrl_s ctrlQ, ctrlD;
	logic [11:0] reloadQ, reloadD;
	logic [11:0] dutyQ, dutyD;
	logic [11:0] shadowQ, shadowD;
	logic [11:0] cntQ, cntD;
	logic ovfFlagQ, ovfFlagD;
	logic cmpFlagQ, cmpFlagD;
	logic lockQ, lockD;
	logic stepQ, stepD;
	logic pwmLevelQ, pwmLevelD;
	logic pwmOutQ, pwmOutD;
	logic [DIV_W-1:0] divQ, divD;
	logic [7:0] rdataQ, rdataD;

	logic cpuTick;
	logic selTick;
	logic running;
	logic tick;
	logic wrap;
	logic [11:0] cmpVal;
	logic cmpHit;
	logic rdTcs;
	logic rdChan;

	// slow mode only slows the cpu clock path; the lite tick has its own rate
	always_comb
	begin
		divD = divQ;
		cpuTick = 1'b1;
		if (lowPower.slow)
		begin
			cpuTick = (divQ == DIV_LAST);
			divD = (divQ == DIV_LAST) ? '0 : divQ + 1'b1;
		end
		else
		begin
			divD = '0;
		end
	end

	always_comb
	begin
		case (ctrlQ.clkSel)
			at_timer_pkg::CLK_LITE: selTick = liteTick;
			at_timer_pkg::CLK_CPU: selTick = cpuTick;
			at_timer_pkg::CLK_OFF: selTick = 1'b0;
			default: selTick = 1'b0;
		endcase
	end

	always_comb
	begin
		running = 1'b1;
		if (lowPower.halt)
		begin
			running = 1'b0;
		end
		else if (lowPower.activeHalt)
		begin
			running = (ctrlQ.clkSel == at_timer_pkg::CLK_LITE) && ctrlQ.overflow_irq_enable;
		end
	end

	assign tick = selTick && running;
	assign wrap = tick && (cntQ == `CNT_TOP);
	assign cmpVal = ctrlQ.oe ? shadowQ : dutyQ;
	// stepQ marks the cycle after the counter moved, so a stopped counter
	// sitting on the compare value raises the event only once
	assign cmpHit = stepQ && !lockQ && (cmpVal != 12'h000) && (cntQ == cmpVal);
	assign rdTcs = regReq.rd && (regReq.addr == `TCS_OFS);
	assign rdChan = regReq.rd && (regReq.addr == `CH_CS_OFS);

	always_comb
	begin
		cntD = cntQ;
		stepD = tick;
		shadowD = shadowQ;
		pwmLevelD = pwmLevelQ;
		if (wrap)
		begin
			cntD = reloadQ;
			shadowD = dutyQ;
			pwmLevelD = 1'b1;
		end
		else if (tick)
		begin
			cntD = cntQ + 12'h001;
		end
		if (cmpHit && ctrlQ.oe)
		begin
			pwmLevelD = 1'b0;
		end
	end

	// flag sets win over any clear landing in the same cycle
	always_comb
	begin
		ovfFlagD = ovfFlagQ;
		if (rdTcs)
		begin
			ovfFlagD = 1'b0;
		end
		else if (tick)
		begin
			ovfFlagD = 1'b0;
		end
		if (wrap)
		begin
			ovfFlagD = 1'b1;
		end
	end

	always_comb
	begin
		cmpFlagD = cmpFlagQ;
		if (rdChan)
		begin
			cmpFlagD = 1'b0;
		end
		if (cmpHit)
		begin
			cmpFlagD = 1'b1;
		end
	end

	// register writes; reserved bits are dropped and read back as zero
	always_comb
	begin
		ctrlD = ctrlQ;
		reloadD = reloadQ;
		dutyD = dutyQ;
		lockD = lockQ;
		if (regReq.wr)
		begin
			case (regReq.addr)
				`TCS_OFS:
				begin
					ctrlD.clkSel = at_timer_pkg::clk_sel_e'(
						regReq.wdata[`TCS_CKSEL_HI:`TCS_CKSEL_LO]);
					ctrlD.overflow_irq_enable = regReq.wdata[`TCS_OVERFLOW_IRQ_ENABLE_BIT];
					ctrlD.compare_irq_enable = regReq.wdata[`TCS_COMPARE_IRQ_ENABLE_BIT];
				end
				`RLD_HI_OFS: reloadD[11:8] = regReq.wdata[3:0];
				`RLD_LO_OFS: reloadD[7:0] = regReq.wdata;
				`DUTY_HI_OFS:
				begin
					dutyD[11:8] = regReq.wdata[3:0];
					lockD = 1'b1;
				end
				`DUTY_LO_OFS:
				begin
					dutyD[7:0] = regReq.wdata;
					lockD = 1'b0;
				end
				`OUT_CTRL_OFS: ctrlD.oe = regReq.wdata[`OCTL_OE_BIT];
				`CH_CS_OFS: ctrlD.pol = regReq.wdata[`CCS_POL_BIT];
				default:
				begin
					ctrlD = ctrlQ;
				end
			endcase
		end
	end

	// read data stands one cycle after the strobe; unmapped reads give zero
	always_comb
	begin
		rdataD = `REG_RESET;
		if (regReq.rd)
		begin
			case (regReq.addr)
				`TCS_OFS:
				begin
					rdataD[`TCS_CKSEL_HI:`TCS_CKSEL_LO] = ctrlQ.clkSel;
					rdataD[`TCS_OVF_BIT] = ovfFlagQ;
					rdataD[`TCS_OVERFLOW_IRQ_ENABLE_BIT] = ctrlQ.overflow_irq_enable;
					rdataD[`TCS_COMPARE_IRQ_ENABLE_BIT] = ctrlQ.compare_irq_enable;
				end
				// the high byte is live, so a carry between the two reads shows
				`CNT_HI_OFS: rdataD[3:0] = cntQ[11:8];
				`CNT_LO_OFS: rdataD = cntQ[7:0];
				`RLD_HI_OFS: rdataD[3:0] = reloadQ[11:8];
				`RLD_LO_OFS: rdataD = reloadQ[7:0];
				`DUTY_HI_OFS: rdataD[3:0] = dutyQ[11:8];
				`DUTY_LO_OFS: rdataD = dutyQ[7:0];
				`OUT_CTRL_OFS: rdataD[`OCTL_OE_BIT] = ctrlQ.oe;
				`CH_CS_OFS:
				begin
					rdataD[`CCS_POL_BIT] = ctrlQ.pol;
					rdataD[`CCS_CMPF_BIT] = cmpFlagQ;
				end
				default: rdataD = `REG_RESET;
			endcase
		end
	end

	// the pin is forced low in compare mode; polarity applies to the pwm wave only
	always_comb
	begin
		pwmOutD = 1'b0;
		if (ctrlQ.oe)
		begin
			pwmOutD = pwmLevelD ^ ctrlD.pol;
		end
	end

	// software-visible settings
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctrlQ <= '0;
			reloadQ <= `CNT_RESET;
			dutyQ <= `CNT_RESET;
			lockQ <= 1'b0;
		end
		else
		begin
			ctrlQ <= ctrlD;
			reloadQ <= reloadD;
			dutyQ <= dutyD;
			lockQ <= lockD;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			divQ <= '0;
		end
		else
		begin
			divQ <= divD;
		end
	end

	// counting state; the shadow only moves on a wrap
	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cntQ <= `CNT_RESET;
			stepQ <= 1'b0;
			shadowQ <= `CNT_RESET;
			pwmLevelQ <= 1'b0;
		end
		else
		begin
			cntQ <= cntD;
			stepQ <= stepD;
			shadowQ <= shadowD;
			pwmLevelQ <= pwmLevelD;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ovfFlagQ <= 1'b0;
			cmpFlagQ <= 1'b0;
		end
		else
		begin
			ovfFlagQ <= ovfFlagD;
			cmpFlagQ <= cmpFlagD;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rdataQ <= `REG_RESET;
		end
		else
		begin
			rdataQ <= rdataD;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pwmOutQ <= 1'b0;
		end
		else
		begin
			pwmOutQ <= pwmOutD;
		end
	end

	assign regRdata = rdataQ;
	assign pwmOut = pwmOutQ;
	assign pwmOutEn = ctrlQ.oe;
	// two separate request lines feed two vectors of the interrupt controller
	assign ovfIrq = ovfFlagQ && ctrlQ.overflow_irq_enable && !cpuIntMask;
	assign cmpIrq = cmpFlagQ && ctrlQ.compare_irq_enable && !cpuIntMask;

	always_comb
	begin
		wakeReq = 1'b0;
		if (lowPower.waitMode)
		begin
			wakeReq = ovfIrq || cmpIrq;
		end
		else if (lowPower.activeHalt && !lowPower.halt)
		begin
			wakeReq = ovfIrq && (ctrlQ.clkSel == at_timer_pkg::CLK_LITE);
		end
	end
endmodule // autoreload_timer_pwm_compare

// *** verif/at_timer_props.sv ***
// port-level checks for the autoreload timer
`timescale 1ns/1ps
`include "at_timer_defines.svh"
module at_timer_props #(
	parameter int SLOW_DIV = 32
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire at_timer_pkg::bus_req_s regReq,
	input wire logic [7:0] regRdata,
	input wire at_timer_pkg::power_s lowPower,
	input wire logic liteTick,
	input wire logic cpuIntMask,
	input wire logic pwmOut,
	input wire logic pwmOutEn,
	input wire logic ovfIrq,
	input wire logic cmpIrq,
	input wire logic wakeReq
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);
	property p_mask;
		cpuIntMask |-> !ovfIrq && !cmpIrq;
	endproperty
	a_mask: assert property (p_mask) else $error("irq while masked");
	property p_cmpOff;
		!pwmOutEn |-> !pwmOut;
	endproperty
	a_cmpOff: assert property (p_cmpOff) else $error("pin driven when off");
	property p_halt;
		lowPower.halt |-> !wakeReq;
	endproperty
	a_halt: assert property (p_halt) else $error("wake in halt");
	property p_wait;
		lowPower == 4'h4 |-> wakeReq == (ovfIrq || cmpIrq);
	endproperty
	a_wait: assert property (p_wait) else $error("wait wake wrong");
	property p_ahalt;
		lowPower == 4'h1 && wakeReq |-> ovfIrq;
	endproperty
	a_ahalt: assert property (p_ahalt) else $error("active-halt wake wrong");
	property p_cntHi;
		regReq.rd && regReq.addr == `CNT_HI_OFS |=> regRdata[7:4] == 4'h0;
	endproperty
	a_cntHi: assert property (p_cntHi) else $error("counter high reserved set");
	property p_chCs;
		regReq.rd && regReq.addr == `CH_CS_OFS |=> regRdata[7:2] == 6'h00;
	endproperty
	a_chCs: assert property (p_chCs) else $error("channel reserved set");
	property p_oe;
		regReq.wr && regReq.addr == `OUT_CTRL_OFS |=> pwmOutEn == $past(regReq.wdata[0]);
	endproperty
	a_oe: assert property (p_oe) else $error("enable not following write");
endmodule // at_timer_props

bind autoreload_timer_pwm_compare at_timer_props #(.SLOW_DIV(SLOW_DIV)) u_props (
	.sys_clk(sys_clk), .rst_b(rst_b), .regReq(regReq), .regRdata(regRdata),
	.lowPower(lowPower), .liteTick(liteTick), .cpuIntMask(cpuIntMask), .pwmOut(pwmOut),
	.pwmOutEn(pwmOutEn), .ovfIrq(ovfIrq), .cmpIrq(cmpIrq), .wakeReq(wakeReq)
);

// *** verif/autoreload_timer_pwm_compare_tb_top.sv ***
// self-checking bench for the autoreload timer
`timescale 1ns/1ps
module autoreload_timer_pwm_compare_tb_top;
	logic sys_clk;
	logic rst_b;
	at_timer_pkg::bus_req_s regReq;
	logic [7:0] regRdata;
	at_timer_pkg::power_s lowPower;
	logic liteTick;
	logic cpuIntMask;
	logic pwmOut;
	logic pwmOutEn;
	logic ovfIrq;
	logic cmpIrq;
	logic wakeReq;
	int error_cnt;
	int num_checks;
	int cyc;
	logic [7:0] cntA;
	logic [7:0] cntB;
	logic [7:0] adr [10] = '{8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h17, 8'h18, 8'h14};
	autoreload_timer_pwm_compare #(
		.SLOW_DIV(4)
	) u_dut (
		.sys_clk(sys_clk), .rst_b(rst_b), .regReq(regReq), .regRdata(regRdata),
		.lowPower(lowPower), .liteTick(liteTick), .cpuIntMask(cpuIntMask), .pwmOut(pwmOut),
		.pwmOutEn(pwmOutEn), .ovfIrq(ovfIrq), .cmpIrq(cmpIrq), .wakeReq(wakeReq)
	);
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 12000)
		begin
			error_cnt++;
			results();
		end
	end
	task automatic results();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regReq.wr <= 1'b1;
		regReq.addr <= a;
		regReq.wdata <= d;
		@(posedge sys_clk);
		regReq.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		regReq.rd <= 1'b1;
		regReq.addr <= a;
		@(posedge sys_clk);
		regReq.rd <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), regRdata, exp);
	endtask
	task automatic rdv(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		regReq.rd <= 1'b1;
		regReq.addr <= a;
		@(posedge sys_clk);
		regReq.rd <= 1'b0;
		#1;
		v = regRdata;
	endtask
	task automatic settle();
		repeat (3) @(posedge sys_clk);
		#1;
	endtask
	// lite ticks keep every count step under bench control
	task automatic tick(input int n);
		repeat (n)
		begin
			@(posedge sys_clk);
			liteTick <= 1'b1;
			@(posedge sys_clk);
			liteTick <= 1'b0;
		end
		settle();
	endtask
	initial
	begin
		sys_clk = 1'b0;
		rst_b = 1'b0;
		regReq = '0;
		lowPower = '0;
		liteTick = 1'b0;
		cpuIntMask = 1'b0;
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		foreach (adr[i]) rd(adr[i], 8'h00);
		wr(8'h0D, 8'h0B);
		rd(8'h0D, 8'h0B);
		wr(8'h0E, 8'hFF);
		rd(8'h0E, 8'h00);
		@(posedge sys_clk);
		lowPower <= 4'h4;
		tick(3);
		rd(8'h13, 8'h00);
		wr(8'h17, 8'h00);
		wr(8'h18, 8'h05);
		wr(8'h17, 8'h00);
		tick(2);
		rd(8'h13, 8'h00);
		wr(8'h18, 8'h07);
		tick(2);
		chk("cmpIrq", {7'h00, cmpIrq}, 8'h01);
		chk("pwmOut", {7'h00, pwmOut}, 8'h00);
		rd(8'h13, 8'h01);
		rd(8'h13, 8'h00);
		rd(8'h0F, 8'h07);
		wr(8'h0D, 8'h0A);
		wr(8'h10, 8'h0F);
		wr(8'h11, 8'hFC);
		wr(8'h17, 8'h0F);
		wr(8'h18, 8'hFE);
		wr(8'h12, 8'h01);
		@(posedge sys_clk);
		lowPower <= 4'h0;
		tick(4089);
		chk("pwmOut", {7'h00, pwmOut}, 8'h01);
		chk("ovfIrq", {7'h00, ovfIrq}, 8'h01);
		rd(8'h0F, 8'hFC);
		rd(8'h0D, 8'h0E);
		rd(8'h0D, 8'h0A);
		tick(2);
		chk("pwmOut", {7'h00, pwmOut}, 8'h00);
		wr(8'h13, 8'h02);
		settle();
		chk("pwmOut", {7'h00, pwmOut}, 8'h01);
		rd(8'h13, 8'h03);
		tick(2);
		chk("pwmOut", {7'h00, pwmOut}, 8'h00);
		chk("ovfIrq", {7'h00, ovfIrq}, 8'h01);
		tick(1);
		chk("ovfIrq", {7'h00, ovfIrq}, 8'h00);
		@(posedge sys_clk);
		lowPower <= 4'h2;
		tick(2);
		rd(8'h0F, 8'hFD);
		@(posedge sys_clk);
		lowPower <= 4'h1;
		tick(1);
		rd(8'h0F, 8'hFE);
		// cpu clock in slow mode: reload 0, one step per 4 cycles with SLOW_DIV 4
		wr(8'h10, 8'h00);
		wr(8'h11, 8'h00);
		@(posedge sys_clk);
		lowPower <= 4'h8;
		wr(8'h0D, 8'h10);
		repeat (40) @(posedge sys_clk);
		rdv(8'h0F, cntA);
		repeat (6) @(posedge sys_clk);
		rdv(8'h0F, cntB);
		chk("slowCount", cntB, cntA + 8'h02);
		rd(8'h0E, 8'h00);
		@(posedge sys_clk);
		cpuIntMask <= 1'b1;
		settle();
		results();
	end
endmodule // autoreload_timer_pwm_compare_tb_top
